/* irq_flag_bank.sv */
// Interrupt request flag bank with shared flags and request selection
//
// Function
// - A source raising its request, or software writing a 1, sets that source's request flag.
// - A flag goes to 0 on a software write of 0, on acknowledge of its interrupt, or on reset.
// - Acknowledging a maskable interrupt clears its flag before the service routine starts.
// - Each flag register takes single-bit and whole-byte writes, each with its own meaning.
// - Low and high bytes of group 0, and of group 1, pair into one halfword written at once.
// - Reset clears every flag register so that nothing is pending afterwards.
// - Every write to a flag register costs two extra execution clocks.
// - UART transmit end and clocked serial A share bit 2 of the group 0 high byte.
// - UART receive end and clocked serial B share bit 3 of the group 0 high byte.
// - UART receive error and timer 1 upper byte share bit 7 of the group 0 high byte.
// - Each of the 25 source positions has its own flag, mask bit and two priority bits that decide its service.
// - External pins use separate rising and falling edge enables; either or both set the flag.
// - Among equal-priority pending requests the lowest default index wins, 0 first, 24 last.
// - The global enable and the two in-service level bits gate acknowledgement of requests.
`timescale 1ns/1ps
`include "irq_flag_consts.svh"

module irq_flag_bank
  import irq_flag_pkg::*;
#(
  parameter int STALL_CLKS = `IFB_WRITE_EXTRA_CLKS
) (
  input  wire logic                        CLK_SYS,
  input  wire logic                        RST,
  input  wire logic [`IFB_NUM_SOURCES-1:0] SRC_IRQ,
  input  wire logic                        CLOCKED_SERIAL_A_IRQ,
  input  wire logic                        CLOCKED_SERIAL_B_IRQ,
  input  wire logic                        TIMER1_UPPER_BYTE_IRQ,
  input  wire logic [`IFB_NUM_PINS-1:0]    PIN_IN,
  input  wire logic [`IFB_NUM_PINS-1:0]    RISING_EDGE_ENABLES,
  input  wire logic [`IFB_NUM_PINS-1:0]    FALLING_EDGE_ENABLES,
  input  wire logic [`IFB_NUM_SOURCES-1:0] MASK_FLAG,
  input  wire prio_t [`IFB_NUM_SOURCES-1:0] PRIORITY,
  input  wire logic                        GLOBAL_IRQ_ENABLE,
  input  wire logic                        IN_SERVICE_LEVEL_LOW,
  input  wire logic                        IN_SERVICE_LEVEL_HIGH,
  input  wire wr_req_t                     WR_REQ,
  input  wire logic                        RD_EN,
  input  wire logic [19:0]                 RD_ADDR,
  input  wire logic                        ACK,
  input  wire logic [4:0]                  ACK_INDEX,
  output logic      [15:0]                 RD_DATA,
  output logic                             WR_BUSY,
  output logic                             IRQ_REQ,
  output logic      [4:0]                  IRQ_INDEX,
  output logic      [1:0]                  IRQ_LEVEL
);

  // ========================================================================
  // Elaboration checks
  if (STALL_CLKS < 1 || STALL_CLKS > 15) begin : g_bad_stall
    $error("STALL_CLKS must lie in 1..15");
  end

  // ========================================================================
  // Source to flag bit map, in default priority order
  localparam int NSRC = `IFB_NUM_SOURCES;
  localparam int NBIT = 8 * `IFB_NUM_REGS;
  localparam logic [5:0] FLAG_POS [NSRC] = '{
    6'd0,  6'd1,  6'd2,  6'd3,  6'd4,  6'd5,  6'd6,  6'd7,
    6'd10, 6'd11, 6'd15, 6'd14, 6'd16, 6'd18, 6'd19, 6'd20,
    6'd21, 6'd22, 6'd23, 6'd24, 6'd30, 6'd31, 6'd32, 6'd33,
    6'd34
  };
  // Source indices fed from the external pins
  localparam logic [4:0] PIN_SRC [`IFB_NUM_PINS] = '{
    5'd2, 5'd3, 5'd4, 5'd5, 5'd6, 5'd7, 5'd22, 5'd23
  };
  localparam logic [7:0] IMPL [`IFB_NUM_REGS] = '{
    `IFB_IMPL_GROUP0_LOW, `IFB_IMPL_GROUP0_HIGH, `IFB_IMPL_GROUP1_LOW,
    `IFB_IMPL_GROUP1_HIGH, `IFB_IMPL_GROUP2_LOW
  };

  // ========================================================================
  // Address decode
  function automatic logic [2:0] reg_index(input logic [19:0] a);
    logic [2:0] r;
    r = `IFB_IDX_NONE;
    unique case (a)
      `IFB_ADDR_GROUP0_LOW:  r = `IFB_IDX_GROUP0_LOW;
      `IFB_ADDR_GROUP0_HIGH: r = `IFB_IDX_GROUP0_HIGH;
      `IFB_ADDR_GROUP1_LOW:  r = `IFB_IDX_GROUP1_LOW;
      `IFB_ADDR_GROUP1_HIGH: r = `IFB_IDX_GROUP1_HIGH;
      `IFB_ADDR_GROUP2_LOW:  r = `IFB_IDX_GROUP2_LOW;
      default:               r = `IFB_IDX_NONE;
    endcase
    return r;
  endfunction

  // ========================================================================
  // Signals
  logic [7:0]             flags_r [`IFB_NUM_REGS];
  logic [NBIT-1:0]        flag_flat;
  logic [NBIT-1:0]        set_flat;
  logic [NBIT-1:0]        ack_flat;
  logic [NBIT-1:0]        wmask_flat;
  logic [NBIT-1:0]        wval_flat;
  logic [NSRC-1:0]        src_set;
  logic [`IFB_NUM_PINS-1:0] pin_hit;
  logic                   wr_accept;
  logic [3:0]             stall_cnt_r;
  logic [2:0]             wr_idx;
  logic                   best_found;
  logic [4:0]             best_idx;
  logic [1:0]             best_lvl;
  logic [1:0]             isp;
  logic                   offer_nxt;

  // ========================================================================
  // Pin edge detection
  genvar gp;
  generate
    for (gp = 0; gp < `IFB_NUM_PINS; gp++) begin : g_pin
      pin_edge_detect u_edge (
        .CLK_SYS  (CLK_SYS),
        .RST      (RST),
        .pin_in   (PIN_IN[gp]),
        .rise_en  (RISING_EDGE_ENABLES[gp]),
        .fall_en  (FALLING_EDGE_ENABLES[gp]),
        .edge_hit (pin_hit[gp])
      );
    end
  endgenerate

  // ========================================================================
  // Hardware set and acknowledge clear vectors
  always_comb begin
    src_set = SRC_IRQ;
    for (int p = 0; p < `IFB_NUM_PINS; p++) begin
      src_set[PIN_SRC[p]] = src_set[PIN_SRC[p]] | pin_hit[p];
    end
    // Shared sources fold onto one flag, mask and priority position
    src_set[`IFB_SRC_UART_TX_END]   = SRC_IRQ[`IFB_SRC_UART_TX_END] |
                                      CLOCKED_SERIAL_A_IRQ;
    src_set[`IFB_SRC_UART_RX_END]   = SRC_IRQ[`IFB_SRC_UART_RX_END] |
                                      CLOCKED_SERIAL_B_IRQ;
    // Both sharers landing on one bit is why software must not use both
    src_set[`IFB_SRC_UART_RX_ERROR] = SRC_IRQ[`IFB_SRC_UART_RX_ERROR] |
                                      TIMER1_UPPER_BYTE_IRQ;
    set_flat = '0;
    ack_flat = '0;
    for (int i = 0; i < NSRC; i++) begin
      set_flat[FLAG_POS[i]] = src_set[i];
      ack_flat[FLAG_POS[i]] = ACK && (ACK_INDEX == 5'(i));
    end
  end

  // ========================================================================
  // Software write decode
  assign wr_accept = WR_REQ.valid && !WR_BUSY;
  assign wr_idx    = reg_index(WR_REQ.addr);

  always_comb begin
    wmask_flat = '0;
    wval_flat  = '0;
    if (wr_accept && wr_idx != `IFB_IDX_NONE) begin
      unique case (WR_REQ.size)
        ACC_BIT: begin
          // Only the addressed bit is touched, so concurrent sets survive
          wmask_flat[{wr_idx, WR_REQ.bit_sel}] = 1'b1;
          wval_flat[{wr_idx, WR_REQ.bit_sel}]  = WR_REQ.data[0];
        end
        ACC_BYTE: begin
          wmask_flat[{wr_idx, 3'h0} +: 8] = 8'hff;
          wval_flat[{wr_idx, 3'h0} +: 8]  = WR_REQ.data[7:0];
        end
        ACC_HALF: begin
          // Halfword only at the even byte of group 0 or group 1
          if (wr_idx == `IFB_IDX_GROUP0_LOW || wr_idx == `IFB_IDX_GROUP1_LOW) begin
            wmask_flat[{wr_idx, 3'h0} +: 16] = 16'hffff;
            wval_flat[{wr_idx, 3'h0} +: 16]  = WR_REQ.data;
          end
        end
        default: begin
          wmask_flat = '0;
        end
      endcase
    end
  end

  // ========================================================================
  // Flag registers
  always_comb begin
    for (int r = 0; r < `IFB_NUM_REGS; r++) begin
      flag_flat[r*8 +: 8] = flags_r[r];
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      for (int r = 0; r < `IFB_NUM_REGS; r++) begin
        flags_r[r] <= `IFB_RESET_VALUE;
      end
    end else begin
      for (int r = 0; r < `IFB_NUM_REGS; r++) begin
        // Hardware set wins over a same-cycle write or acknowledge clear
        flags_r[r] <= (((flags_r[r] & ~wmask_flat[r*8 +: 8]) |
                        (wval_flat[r*8 +: 8] & wmask_flat[r*8 +: 8])) &
                       ~ack_flat[r*8 +: 8] | set_flat[r*8 +: 8]) & IMPL[r];
      end
    end
  end

  // ========================================================================
  // Write stall: each accepted write holds the instruction for extra clocks
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      stall_cnt_r <= 4'h0;
      WR_BUSY     <= 1'b0;
    end else if (wr_accept) begin
      stall_cnt_r <= 4'(STALL_CLKS);
      WR_BUSY     <= 1'b1;
    end else begin
      if (stall_cnt_r != 4'h0) begin
        stall_cnt_r <= stall_cnt_r - 4'h1;
      end
      WR_BUSY <= (stall_cnt_r > 4'h1);
    end
  end

  // ========================================================================
  // Register read: low byte at the address, next byte of a pair above it
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      RD_DATA <= 16'h0000;
    end else if (RD_EN) begin
      RD_DATA <= 16'h0000;
      unique case (reg_index(RD_ADDR))
        `IFB_IDX_GROUP0_LOW:  RD_DATA <= {flags_r[1], flags_r[0]};
        `IFB_IDX_GROUP0_HIGH: RD_DATA <= {8'h00, flags_r[1]};
        `IFB_IDX_GROUP1_LOW:  RD_DATA <= {flags_r[3], flags_r[2]};
        `IFB_IDX_GROUP1_HIGH: RD_DATA <= {8'h00, flags_r[3]};
        `IFB_IDX_GROUP2_LOW:  RD_DATA <= {8'h00, flags_r[4]};
        default:              RD_DATA <= 16'h0000;
      endcase
    end
  end

  // ========================================================================
  // Request selection
  assign isp = {IN_SERVICE_LEVEL_HIGH, IN_SERVICE_LEVEL_LOW};

  always_comb begin
    best_found = 1'b0;
    best_idx   = 5'h00;
    best_lvl   = 2'h3;
    for (int i = 0; i < NSRC; i++) begin
      if (flag_flat[FLAG_POS[i]] && !MASK_FLAG[i]) begin
        // Strict compare keeps the lower index on a tie
        if (!best_found || {PRIORITY[i].prio_high, PRIORITY[i].prio_low} < best_lvl) begin
          best_found = 1'b1;
          best_idx   = 5'(i);
          best_lvl   = {PRIORITY[i].prio_high, PRIORITY[i].prio_low};
        end
      end
    end
    offer_nxt = best_found && GLOBAL_IRQ_ENABLE &&
                ((best_lvl < isp) || (isp == `IFB_ISP_ACCEPT_ALL));
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      IRQ_REQ   <= 1'b0;
      IRQ_INDEX <= 5'h00;
      IRQ_LEVEL <= 2'h3;
    end else begin
      // A request just acknowledged is withdrawn at once
      IRQ_REQ   <= offer_nxt && !(ACK && ACK_INDEX == best_idx);
      IRQ_INDEX <= best_idx;
      IRQ_LEVEL <= best_lvl;
    end
  end

endmodule

/* irq_flag_consts.svh */
// Constants for the interrupt request flag bank
`ifndef IRQ_FLAG_CONSTS_SVH
`define IRQ_FLAG_CONSTS_SVH

// ==========================================================================
// Register addresses
`define IFB_ADDR_GROUP0_LOW   20'hfffe0
`define IFB_ADDR_GROUP0_HIGH  20'hfffe1
`define IFB_ADDR_GROUP1_LOW   20'hfffe2
`define IFB_ADDR_GROUP1_HIGH  20'hfffe3
`define IFB_ADDR_GROUP2_LOW   20'hfffd0

// ==========================================================================
// Register indices inside the bank
`define IFB_IDX_GROUP0_LOW    3'h0
`define IFB_IDX_GROUP0_HIGH   3'h1
`define IFB_IDX_GROUP1_LOW    3'h2
`define IFB_IDX_GROUP1_HIGH   3'h3
`define IFB_IDX_GROUP2_LOW    3'h4
`define IFB_IDX_NONE          3'h7
`define IFB_NUM_REGS          5

// ==========================================================================
// Implemented bits per register; the rest hold zero
`define IFB_IMPL_GROUP0_LOW   8'hff
`define IFB_IMPL_GROUP0_HIGH  8'hcc
`define IFB_IMPL_GROUP1_LOW   8'hfd
`define IFB_IMPL_GROUP1_HIGH  8'hc1
`define IFB_IMPL_GROUP2_LOW   8'h07
`define IFB_RESET_VALUE       8'h00

// ==========================================================================
// Sources, pins and timing
`define IFB_NUM_SOURCES       25
`define IFB_NUM_PINS          8
`define IFB_SRC_UART_TX_END   8
`define IFB_SRC_UART_RX_END   9
`define IFB_SRC_UART_RX_ERROR 10
`define IFB_WRITE_EXTRA_CLKS  2
`define IFB_ISP_ACCEPT_ALL    2'h3

`endif

/* irq_flag_pkg.sv */
// Types shared by the interrupt request flag bank
package irq_flag_pkg;

  // ========================================================================
  // Access width of a flag register write
  typedef enum logic [1:0] {
    ACC_BIT  = 2'h0,
    ACC_BYTE = 2'h1,
    ACC_HALF = 2'h3
  } access_size_t;

  // ========================================================================
  // One write instruction as seen by the flag bank
  typedef struct packed {
    logic         valid;
    logic [19:0]  addr;
    access_size_t size;
    logic [2:0]   bit_sel;
    logic [15:0]  data;
  } wr_req_t;

  // ========================================================================
  // Priority setting of one source
  typedef struct packed {
    logic prio_high;
    logic prio_low;
  } prio_t;

endpackage

/* pin_edge_detect.sv */
// Edge detector for one external interrupt pin
`timescale 1ns/1ps
`include "irq_flag_consts.svh"

module pin_edge_detect (
  input  wire logic CLK_SYS,
  input  wire logic RST,
  input  wire logic pin_in,
  input  wire logic rise_en,
  input  wire logic fall_en,
  output logic      edge_hit
);

  logic pin_d_r;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pin_d_r <= 1'b0;
    end else begin
      pin_d_r <= pin_in;
    end
  end

  // Either edge or both may fire; with both enables clear the pin is inert
  assign edge_hit = (rise_en && pin_in && !pin_d_r) ||
                    (fall_en && !pin_in && pin_d_r);

endmodule

/* irq_flag_bank_props.sv */
// Property checker for the interrupt request flag bank
`timescale 1ns/1ps
`include "irq_flag_consts.svh"
module irq_flag_bank_props
  import irq_flag_pkg::*;
#(
  parameter int STALL_CLKS = 2
) (
  input wire logic         CLK_SYS,
  input wire logic         RST,
  input wire logic [24:0]  SRC_IRQ,
  input wire logic [24:0]  MASK_FLAG,
  input wire prio_t [24:0] PRIORITY,
  input wire logic         GLOBAL_IRQ_ENABLE,
  input wire logic         IN_SERVICE_LEVEL_LOW,
  input wire logic         IN_SERVICE_LEVEL_HIGH,
  input wire wr_req_t      WR_REQ,
  input wire logic         RD_EN,
  input wire logic [19:0]  RD_ADDR,
  input wire logic         ACK,
  input wire logic [4:0]   ACK_INDEX,
  input wire logic [15:0]  RD_DATA,
  input wire logic         WR_BUSY,
  input wire logic         IRQ_REQ,
  input wire logic [4:0]   IRQ_INDEX,
  input wire logic [1:0]   IRQ_LEVEL
);
  logic [3:0]   busy_cnt_r;
  logic [24:0]  mask_r;
  prio_t [24:0] prio_r;
  logic         gie_r;
  logic [1:0]   isp_r;
  wire          isp_all = IN_SERVICE_LEVEL_HIGH && IN_SERVICE_LEVEL_LOW;

  // ======================================================================
  // Helpers
  // Copies line up the level inputs with the registered request outputs
  always_ff @(posedge CLK_SYS) begin
    mask_r <= MASK_FLAG;
    prio_r <= PRIORITY;
    gie_r  <= GLOBAL_IRQ_ENABLE;
    isp_r  <= {IN_SERVICE_LEVEL_HIGH, IN_SERVICE_LEVEL_LOW};
  end
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      busy_cnt_r <= 4'h0;
    end else begin
      busy_cnt_r <= WR_BUSY ? busy_cnt_r + 4'h1 : 4'h0;
    end
  end
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  // ======================================================================
  // Properties
  property p_busy_start;
    WR_REQ.valid && !WR_BUSY |=> WR_BUSY;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("write not stalled");
  property p_busy_end;
    busy_cnt_r == STALL_CLKS |-> !WR_BUSY;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("stall too long");
  property p_busy_fall;
    $fell(WR_BUSY) |-> busy_cnt_r == STALL_CLKS;
  endproperty
  a_busy_fall: assert property (p_busy_fall) else $error("stall too short");
  property p_unmapped;
    RD_EN && !(RD_ADDR inside {`IFB_ADDR_GROUP0_LOW, `IFB_ADDR_GROUP0_HIGH,
      `IFB_ADDR_GROUP1_LOW, `IFB_ADDR_GROUP1_HIGH, `IFB_ADDR_GROUP2_LOW}) |=> RD_DATA == 16'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
  property p_ack_drop;
    ACK && IRQ_REQ && ACK_INDEX == IRQ_INDEX && !SRC_IRQ[ACK_INDEX]
      |=> !IRQ_REQ || IRQ_INDEX != $past(ACK_INDEX);
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("acked request stays");
  property p_mask_gate;
    IRQ_REQ |-> !mask_r[IRQ_INDEX] && gie_r;
  endproperty
  a_mask_gate: assert property (p_mask_gate) else $error("masked request offered");
  property p_level;
    IRQ_REQ |-> IRQ_LEVEL == prio_r[IRQ_INDEX];
  endproperty
  a_level: assert property (p_level) else $error("wrong request level");
  property p_isp;
    IRQ_REQ |-> isp_r == 2'h3 || IRQ_LEVEL < isp_r;
  endproperty
  a_isp: assert property (p_isp) else $error("level not accepted");
  property p_offer;
    (SRC_IRQ & ~MASK_FLAG) != 25'h0 && GLOBAL_IRQ_ENABLE && isp_all && !ACK
      ##1 !ACK && GLOBAL_IRQ_ENABLE && isp_all |=> IRQ_REQ;
  endproperty
  a_offer: assert property (p_offer) else $error("set source not offered");
endmodule

/* cpu_ack_model.sv */
// Behavioural CPU core that acknowledges offered requests after a delay
`timescale 1ns/1ps
module cpu_ack_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       enable,
  input  wire logic [3:0] delay,
  input  wire logic       irq_req,
  input  wire logic [4:0] irq_index,
  output logic            ack,
  output logic [4:0]      ack_index
);
  logic [3:0] wait_r;

  // ======================================================================
  // Acknowledge
  // Idle index toggles so the bank can never lean on a stale value
  always @(negedge clk or posedge rst) begin
    if (rst) begin
      ack       <= 1'b0;
      ack_index <= 5'h1f;
      wait_r    <= 4'h0;
    end else if (enable && irq_req && !ack && wait_r >= delay) begin
      ack       <= 1'b1;
      ack_index <= irq_index;
      wait_r    <= 4'h0;
    end else begin
      ack       <= 1'b0;
      ack_index <= ~ack_index;
      wait_r    <= (enable && irq_req && !ack) ? wait_r + 4'h1 : 4'h0;
    end
  end
endmodule

/* test_irq_flag_bank.sv */
// Self-checking testbench for the interrupt request flag bank
`timescale 1ns/1ps
module test_irq_flag_bank
  import irq_flag_pkg::*;
;
  typedef struct packed {
    logic [7:0]   a;
    access_size_t s;
    logic [2:0]   b;
    logic [15:0]  d;
    logic [7:0]   ra;
    logic [15:0]  e;
  } row_t;
  logic         clk, rst, csa, csb, tm1, gie, rd_en, ack, busy, irq_req, pen;
  logic [24:0]  src, mask;
  logic [7:0]   pin, rise, fall;
  prio_t [24:0] prio;
  logic [1:0]   isp, irq_lvl;
  wr_req_t      wreq;
  logic [19:0]  rd_addr;
  logic [4:0]   ack_idx, irq_idx;
  logic [15:0]  rd_data;
  logic [3:0]   pdel;
  int           fail_count = 0;
  int           cmp_count = 0;
  logic [15:0]  sh [3] = '{16'h0400, 16'h0800, 16'h8000};
  row_t         rows [13] = '{
    '{8'he0, ACC_BYTE, 3'h0, 16'h00a5, 8'he0, 16'h00a5},
    '{8'he1, ACC_BYTE, 3'h0, 16'h00ff, 8'he1, 16'h00cc},
    '{8'he0, ACC_BIT,  3'h1, 16'h0001, 8'he0, 16'hcca7},
    '{8'he0, ACC_HALF, 3'h0, 16'h5678, 8'he0, 16'h4478},
    '{8'he1, ACC_HALF, 3'h0, 16'hffff, 8'he1, 16'h0044},
    '{8'he2, ACC_HALF, 3'h0, 16'hffff, 8'he2, 16'hc1fd},
    '{8'he3, ACC_BYTE, 3'h0, 16'h0041, 8'he3, 16'h0041},
    '{8'hd0, ACC_BYTE, 3'h0, 16'h00ff, 8'hd0, 16'h0007},
    '{8'hd0, ACC_HALF, 3'h0, 16'h0000, 8'hd0, 16'h0007},
    '{8'h00, ACC_BYTE, 3'h0, 16'h00ff, 8'h00, 16'h0000},
    '{8'he0, ACC_HALF, 3'h0, 16'h0000, 8'he0, 16'h0000},
    '{8'he2, ACC_HALF, 3'h0, 16'h0000, 8'he2, 16'h0000},
    '{8'hd0, ACC_BYTE, 3'h0, 16'h0000, 8'hd0, 16'h0000}};

  irq_flag_bank #(.STALL_CLKS(2)) uut (
    .CLK_SYS(clk), .RST(rst), .SRC_IRQ(src), .CLOCKED_SERIAL_A_IRQ(csa),
    .CLOCKED_SERIAL_B_IRQ(csb), .TIMER1_UPPER_BYTE_IRQ(tm1), .PIN_IN(pin),
    .RISING_EDGE_ENABLES(rise), .FALLING_EDGE_ENABLES(fall), .MASK_FLAG(mask),
    .PRIORITY(prio), .GLOBAL_IRQ_ENABLE(gie), .IN_SERVICE_LEVEL_LOW(isp[0]),
    .IN_SERVICE_LEVEL_HIGH(isp[1]), .WR_REQ(wreq), .RD_EN(rd_en), .RD_ADDR(rd_addr),
    .ACK(ack), .ACK_INDEX(ack_idx), .RD_DATA(rd_data), .WR_BUSY(busy),
    .IRQ_REQ(irq_req), .IRQ_INDEX(irq_idx), .IRQ_LEVEL(irq_lvl));
  cpu_ack_model cpu (.clk(clk), .rst(rst), .enable(pen), .delay(pdel), .irq_req(irq_req),
    .irq_index(irq_idx), .ack(ack), .ack_index(ack_idx));

  // ======================================================================
  // Tasks
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wr(logic [19:0] a, access_size_t s, logic [2:0] b, logic [15:0] d,
                    logic [24:0] hw);
    @(negedge clk);
    wreq <= '{1'b1, a, s, b, d};
    src <= hw;
    @(negedge clk);
    wreq.valid <= 1'b0;
    src <= '0;
    check("busy", 16'(busy), 16'h1);
    @(negedge clk);
    check("busy", 16'(busy), 16'h1);
    @(negedge clk);
    check("busy", 16'(busy), 16'h0);
  endtask
  task automatic rd(logic [19:0] a, logic [15:0] e);
    @(negedge clk);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(negedge clk);
    rd_en <= 1'b0;
    check("rd_data", rd_data, e);
  endtask
  task automatic fire(logic [27:0] v);
    @(negedge clk);
    {tm1, csb, csa, src} <= v;
    @(negedge clk);
    {tm1, csb, csa, src} <= '0;
  endtask
  task automatic take(logic [4:0] idx);
    int n;
    n = 0;
    while (ack !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    check("ack_index", 16'({ack, ack_idx}), 16'({1'b1, idx}));
    @(negedge clk);
  endtask

  // ======================================================================
  // Clock, watchdog and sequence
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #40000;
    fail_count++;
    wrap_up();
  end
  initial begin
    rst = 1'b1;
    {tm1, csb, csa, src} = '0;
    pin = 8'h40;
    {rise, fall, mask, gie, rd_en, rd_addr, pen, pdel} = '0;
    prio = '1;
    isp = 2'h3;
    wreq = '0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    check("irq_level", 16'({irq_req, irq_lvl}), 16'h3);
    rd(20'hfffe0, 16'h0000);
    rd(20'hfffe2, 16'h0000);
    rd(20'hfffd0, 16'h0000);
    foreach (rows[i]) begin
      wr({12'hfff, rows[i].a}, rows[i].s, rows[i].b, rows[i].d, '0);
      rd({12'hfff, rows[i].ra}, rows[i].e);
    end
    rise = 8'h01;
    fall = 8'h40;
    @(negedge clk);
    pin = 8'h01;
    repeat (2) @(negedge clk);
    rd(20'hfffe0, 16'h0004);
    rd(20'hfffd0, 16'h0001);
    wr(20'hfffe0, ACC_HALF, 3'h0, 16'h0000, '0);
    wr(20'hfffd0, ACC_BYTE, 3'h0, 16'h0000, '0);
    // Each sharer fires alone, never receive error beside the timer
    for (int i = 0; i < 6; i++) begin
      fire(i < 3 ? 28'h2000000 << i : 28'h100 << (i - 3));
      rd(20'hfffe0, sh[i % 3]);
      wr(20'hfffe0, ACC_HALF, 3'h0, 16'h0000, '0);
    end
    wr(20'hfffe0, ACC_BIT, 3'h1, 16'h0001, '0);
    wr(20'hfffe0, ACC_BIT, 3'h1, 16'h0000, 25'h1);
    rd(20'hfffe0, 16'h0001);
    wr(20'hfffe0, ACC_HALF, 3'h0, 16'h0000, '0);
    gie = 1'b1;
    pen = 1'b1;
    prio[21] = 2'h0;
    for (int d = 0; d < 2; d++) begin
      pdel = 4'(d * 5);
      fire(28'h0300020);
      take(5'd21);
      take(5'd5);
      take(5'd20);
      check("irq_req", 16'(irq_req), 16'h0);
      rd(20'hfffe2, 16'h0000);
      rd(20'hfffe0, 16'h0000);
    end
    mask[5] = 1'b1;
    prio[5] = 2'h1;
    fire(28'h20);
    repeat (4) @(negedge clk);
    check("irq_req", 16'(irq_req), 16'h0);
    mask[5] = 1'b0;
    isp = 2'h0;
    repeat (4) @(negedge clk);
    check("irq_req", 16'(irq_req), 16'h0);
    isp = 2'h3;
    @(negedge clk);
    check("irq_level", 16'({irq_req, irq_lvl}), 16'h5);
    take(5'd5);
    // Reset in mid-run during a write stall; rising enables off so no pin edge follows
    rise = '0;
    @(negedge clk);
    wreq <= '{1'b1, 20'hfffe0, ACC_BYTE, 3'h0, 16'h00ff};
    @(negedge clk);
    wreq.valid <= 1'b0;
    check("busy", 16'(busy), 16'h1);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    check("busy", 16'(busy), 16'h0);
    check("irq_level", 16'({irq_req, irq_lvl}), 16'h3);
    rd(20'hfffe0, 16'h0000);
    wrap_up();
  end
endmodule

bind irq_flag_bank irq_flag_bank_props #(.STALL_CLKS(STALL_CLKS)) chk (
  .CLK_SYS(CLK_SYS), .RST(RST), .SRC_IRQ(SRC_IRQ), .MASK_FLAG(MASK_FLAG),
  .PRIORITY(PRIORITY), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE),
  .IN_SERVICE_LEVEL_LOW(IN_SERVICE_LEVEL_LOW), .IN_SERVICE_LEVEL_HIGH(IN_SERVICE_LEVEL_HIGH),
  .WR_REQ(WR_REQ), .RD_EN(RD_EN), .RD_ADDR(RD_ADDR), .ACK(ACK), .ACK_INDEX(ACK_INDEX),
  .RD_DATA(RD_DATA), .WR_BUSY(WR_BUSY), .IRQ_REQ(IRQ_REQ), .IRQ_INDEX(IRQ_INDEX),
  .IRQ_LEVEL(IRQ_LEVEL));
